//--- rtl/vstcfg_pkg.sv
// Package: register map, field positions, reset values and state codes for the sync timing block
package vstcfg_pkg;
	localparam int          VSTCFG_ADDR_W         = 12;
	localparam int          VSTCFG_DATA_W         = 8;
	// Register byte addresses
	localparam logic [11:0] VSTCFG_VS_LOW_TOP     = 12'h3E4;
	localparam logic [11:0] VSTCFG_VS_LOW_MID     = 12'h3E5;
	localparam logic [11:0] VSTCFG_VS_LOW_LO      = 12'h3E6;
	localparam logic [11:0] VSTCFG_DELAY_HI       = 12'h3E7;
	localparam logic [11:0] VSTCFG_DELAY_MID      = 12'h3E8;
	localparam logic [11:0] VSTCFG_DELAY_LO       = 12'h3E9;
	localparam logic [11:0] VSTCFG_HS_HIGH_HI     = 12'h3EA;
	localparam logic [11:0] VSTCFG_HS_HIGH_LO     = 12'h3EB;
	localparam logic [11:0] VSTCFG_HS_LOW_HI      = 12'h3EC;
	localparam logic [11:0] VSTCFG_HS_LOW_LO      = 12'h3ED;
	localparam logic [11:0] VSTCFG_PULSES_HI      = 12'h3EE;
	localparam logic [11:0] VSTCFG_PULSES_LO      = 12'h3EF;
	// Register window: lowest address and number of byte registers
	localparam logic [11:0] VSTCFG_BASE           = 12'h3E4;
	localparam int          VSTCFG_NREG           = 12;
	localparam logic [7:0]  VSTCFG_RESET_BYTE     = 8'h00;
	localparam logic [7:0]  VSTCFG_UNMAPPED_BYTE  = 8'h00;
	// Field positions inside the wide counts
	localparam int          VSTCFG_TOP_LSB        = 16;
	localparam int          VSTCFG_MID_LSB        = 8;
	localparam int          VSTCFG_BOT_LSB        = 0;
	localparam int          VSTCFG_CNT_W          = 24;
	// Timing counter phases
	typedef enum logic [1:0]
	{
		VSTCFG_H_IDLE  = 2'b00,
		VSTCFG_H_DELAY = 2'b01,
		VSTCFG_H_HIGH  = 2'b10,
		VSTCFG_H_LOW   = 2'b11
	} vstcfg_hstate_t;
endpackage : vstcfg_pkg

//--- rtl/vstcfg_regs.sv
// Byte-wide configuration register file with read-back, reached over the configuration port
`timescale 1ns/1ns
module vstcfg_regs
(
	input  wire logic                           clock,
	input  wire logic                           arst_n,
	input  wire logic                           cfg_write,
	input  wire logic [vstcfg_pkg::VSTCFG_ADDR_W-1:0] cfg_addr,
	input  wire logic [7:0]                     cfg_wdata,
	output logic      [7:0]                     cfg_rdata,
	output logic      [8*vstcfg_pkg::VSTCFG_NREG-1:0] reg_flat
);
	import vstcfg_pkg::*;

	logic [7:0] regs      [VSTCFG_NREG];
	logic [7:0] next_regs [VSTCFG_NREG];
	logic [7:0] next_cfg_rdata;

	// Index of an address inside the window; out-of-window addresses give an illegal index
	function automatic logic [11:0] reg_index(input logic [11:0] addr);
		reg_index = addr - VSTCFG_BASE;
	endfunction : reg_index

	// Write decode and read mux; unmapped reads answer zero
	always_comb
	begin
		logic [11:0] idx;
		idx = reg_index(cfg_addr);
		for (int i = 0; i < VSTCFG_NREG; i++)
			next_regs[i] = regs[i];
		next_cfg_rdata = VSTCFG_UNMAPPED_BYTE;
		if (idx < 12'(VSTCFG_NREG))
		begin
			next_cfg_rdata = regs[idx[3:0]];
			if (cfg_write)
				next_regs[idx[3:0]] = cfg_wdata;
		end
	end

	// Register storage and registered read data
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < VSTCFG_NREG; i++)
				regs[i] <= VSTCFG_RESET_BYTE;
			cfg_rdata <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < VSTCFG_NREG; i++)
				regs[i] <= next_regs[i];
			cfg_rdata <= next_cfg_rdata;
		end
	end

	// Flattened view, register at window index i in byte lane i
	always_comb
	begin
		for (int i = 0; i < VSTCFG_NREG; i++)
			reg_flat[8*i +: 8] = regs[i];
	end
endmodule : vstcfg_regs

//--- rtl/vstcfg_timing.sv
// Top level: sync timing registers and the vertical/horizontal sync generator they steer
//
// Summary of operation
// - Vsync low count bits 15:8 own register.
// - Vsync low count bits 7:0 next address.
// - 24-bit vsync-to-hsync delay, top byte first.
// - Delay middle and bottom bytes follow, descending.
// - Hsync high 16-bit count, upper byte register.
// - Hsync high lower byte follows upper byte.
// - Hsync low 16-bit count, upper byte register.
// - Vsync low count bits 23:16 below middle.
// - Hsync low lower byte follows upper byte.
// - Emit per-frame count of hsync pulses.
`timescale 1ns/1ns
module vstcfg_timing
(
	input  wire logic                                 clock,
	input  wire logic                                 arst_n,
	input  wire logic                                 pixel_en,
	input  wire logic                                 cfg_write,
	input  wire logic [vstcfg_pkg::VSTCFG_ADDR_W-1:0] cfg_addr,
	input  wire logic [7:0]                           cfg_wdata,
	input  wire logic [23:0]                          vsync_high_count,
	output logic      [7:0]                           cfg_rdata,
	output logic                                      vsync_out,
	output logic                                      hsync_out
);
	import vstcfg_pkg::*;

	logic [8*VSTCFG_NREG-1:0] reg_flat;
	logic [23:0]              vsync_low_count;
	logic [23:0]              vert_to_horiz_delay;
	logic [15:0]              hsync_high_count;
	logic [15:0]              hsync_low_count;
	logic [15:0]              pulses_per_frame;

	vstcfg_hstate_t           hstate;
	vstcfg_hstate_t           next_hstate;
	logic [23:0]              vcount;
	logic [23:0]              next_vcount;
	logic [23:0]              hcount;
	logic [23:0]              next_hcount;
	logic [15:0]              pulse_count;
	logic [15:0]              next_pulse_count;
	logic                     next_vsync_out;
	logic                     next_hsync_out;
	logic                     vsync_fall;

	// Byte of the register at a given address, taken from the flat view
	function automatic logic [7:0] reg_byte(input logic [8*VSTCFG_NREG-1:0] f,
		input logic [11:0] addr);
		logic [11:0] idx;
		idx = addr - VSTCFG_BASE;
		reg_byte = f[8*idx[3:0] +: 8];
	endfunction : reg_byte

	// A period of zero is treated as one cycle so a phase never stalls forever
	function automatic logic [23:0] last_tick(input logic [23:0] period);
		last_tick = (period == 24'h000000) ? 24'h000000 : period - 24'h000001;
	endfunction : last_tick

	vstcfg_regs u_regs
	(
		.clock     (clock),
		.arst_n    (arst_n),
		.cfg_write (cfg_write),
		.cfg_addr  (cfg_addr),
		.cfg_wdata (cfg_wdata),
		.cfg_rdata (cfg_rdata),
		.reg_flat  (reg_flat)
	);

	// Assemble wide counts from the byte registers, most significant at the lowest address
	always_comb
	begin
		vsync_low_count[23:16]     = reg_byte(reg_flat, VSTCFG_VS_LOW_TOP);
		vsync_low_count[15:8]      = reg_byte(reg_flat, VSTCFG_VS_LOW_MID);
		vsync_low_count[7:0]       = reg_byte(reg_flat, VSTCFG_VS_LOW_LO);
		vert_to_horiz_delay[23:16] = reg_byte(reg_flat, VSTCFG_DELAY_HI);
		vert_to_horiz_delay[15:8]  = reg_byte(reg_flat, VSTCFG_DELAY_MID);
		vert_to_horiz_delay[7:0]   = reg_byte(reg_flat, VSTCFG_DELAY_LO);
		hsync_high_count[15:8]     = reg_byte(reg_flat, VSTCFG_HS_HIGH_HI);
		hsync_high_count[7:0]      = reg_byte(reg_flat, VSTCFG_HS_HIGH_LO);
		hsync_low_count[15:8]      = reg_byte(reg_flat, VSTCFG_HS_LOW_HI);
		hsync_low_count[7:0]       = reg_byte(reg_flat, VSTCFG_HS_LOW_LO);
		pulses_per_frame[15:8]     = reg_byte(reg_flat, VSTCFG_PULSES_HI);
		pulses_per_frame[7:0]      = reg_byte(reg_flat, VSTCFG_PULSES_LO);
	end

	// Vertical sync: free-running high/low alternation on pixel enables
	always_comb
	begin
		next_vcount    = vcount;
		next_vsync_out = vsync_out;
		vsync_fall     = 1'b0;
		if (pixel_en)
		begin
			if (vsync_out)
			begin
				if (vcount >= last_tick(vsync_high_count))
				begin
					next_vsync_out = 1'b0;
					next_vcount    = 24'h000000;
					vsync_fall     = 1'b1;
				end
				else
					next_vcount = vcount + 24'h000001;
			end
			else
			begin
				if (vcount >= last_tick(vsync_low_count))
				begin
					next_vsync_out = 1'b1;
					next_vcount    = 24'h000000;
				end
				else
					next_vcount = vcount + 24'h000001;
			end
		end
	end

	// Horizontal sync: delay from the vsync falling edge, then a counted pulse train
	always_comb
	begin
		next_hstate      = hstate;
		next_hcount      = hcount;
		next_pulse_count = pulse_count;
		next_hsync_out   = hsync_out;
		if (pixel_en)
		begin
			if (vsync_fall)
			begin
				// A new frame restarts the train even if the old one is unfinished
				next_hstate      = VSTCFG_H_DELAY;
				next_hcount      = 24'h000000;
				next_pulse_count = 16'h0000;
				next_hsync_out   = 1'b0;
			end
			else
			begin
				unique case (hstate)
					VSTCFG_H_IDLE:
						next_hsync_out = 1'b0;
					VSTCFG_H_DELAY:
						if (hcount >= last_tick(vert_to_horiz_delay))
						begin
							next_hcount = 24'h000000;
							if (pulses_per_frame == 16'h0000)
								next_hstate = VSTCFG_H_IDLE;
							else
							begin
								next_hstate    = VSTCFG_H_HIGH;
								next_hsync_out = 1'b1;
							end
						end
						else
							next_hcount = hcount + 24'h000001;
					VSTCFG_H_HIGH:
						if (hcount >= last_tick({8'h00, hsync_high_count}))
						begin
							next_hcount      = 24'h000000;
							next_hsync_out   = 1'b0;
							next_pulse_count = pulse_count + 16'h0001;
							if (pulse_count + 16'h0001 >= pulses_per_frame)
								next_hstate = VSTCFG_H_IDLE;
							else
								next_hstate = VSTCFG_H_LOW;
						end
						else
							next_hcount = hcount + 24'h000001;
					VSTCFG_H_LOW:
						if (hcount >= last_tick({8'h00, hsync_low_count}))
						begin
							next_hcount    = 24'h000000;
							next_hstate    = VSTCFG_H_HIGH;
							next_hsync_out = 1'b1;
						end
						else
							next_hcount = hcount + 24'h000001;
				endcase
			end
		end
	end

	// State registers for both generators
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vcount      <= 24'h000000;
			vsync_out   <= 1'b1;
			hstate      <= VSTCFG_H_IDLE;
			hcount      <= 24'h000000;
			pulse_count <= 16'h0000;
			hsync_out   <= 1'b0;
		end
		else
		begin
			vcount      <= next_vcount;
			vsync_out   <= next_vsync_out;
			hstate      <= next_hstate;
			hcount      <= next_hcount;
			pulse_count <= next_pulse_count;
			hsync_out   <= next_hsync_out;
		end
	end
endmodule : vstcfg_timing

//--- testbench/vstcfg_asserts.sv
// Checker: read-back and sync edge relations seen at the block's ports
`timescale 1ns/1ns
module vstcfg_asserts
(
	input wire logic                                 clock,
	input wire logic                                 arst_n,
	input wire logic                                 pixel_en,
	input wire logic                                 cfg_write,
	input wire logic [vstcfg_pkg::VSTCFG_ADDR_W-1:0] cfg_addr,
	input wire logic [7:0]                           cfg_wdata,
	input wire logic [23:0]                          vsync_high_count,
	input wire logic [7:0]                           cfg_rdata,
	input wire logic                                 vsync_out,
	input wire logic                                 hsync_out
);
	import vstcfg_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Outside the byte window nothing answers
	wire logic unmapped = (cfg_addr < VSTCFG_BASE) || (cfg_addr > VSTCFG_PULSES_LO);
	chk_unmapped_reads_zero: assert property (unmapped |=> cfg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_write_reads_back: assert property ((cfg_write && !unmapped) ##1 (!cfg_write && $stable(cfg_addr)) |=> cfg_rdata == $past(cfg_wdata, 2))
		else $error("written byte not read back");
	chk_rdata_holds_still: assert property ((!cfg_write ##1 $stable(cfg_addr)) |=> $stable(cfg_rdata))
		else $error("read data moved without cause");
	chk_rdata_change_cause: assert property ($changed(cfg_rdata) |-> $past(cfg_write, 2) || $past(cfg_addr) != $past(cfg_addr, 2))
		else $error("read data changed without cause");
	chk_vsync_needs_enable: assert property ($changed(vsync_out) |-> $past(pixel_en))
		else $error("vsync moved without pixel enable");
	chk_hsync_needs_enable: assert property ($changed(hsync_out) |-> $past(pixel_en))
		else $error("hsync moved without pixel enable");
	chk_fall_clears_hsync: assert property ($fell(vsync_out) |-> !hsync_out)
		else $error("hsync high right after vsync fall");
	chk_no_rise_at_fall: assert property ($rose(hsync_out) |-> !$fell(vsync_out))
		else $error("hsync rose at vsync fall");
endmodule : vstcfg_asserts

//--- testbench/testbench.sv
// Testbench: register access, reset values and sync waveform timing
`timescale 1ns/1ns
module testbench;
	import vstcfg_pkg::*;
	logic        clock, arst_n, pixel_en, cfg_write, vsync_out, hsync_out;
	logic [11:0] cfg_addr;
	logic [7:0]  cfg_wdata, cfg_rdata, v;
	logic [23:0] vsync_high_count;
	int          n_mismatch = 0, check_count = 0, cyc = 0, n_rise = 0;
	int          i, n0, t0, t1, t2, tv;
	logic        half_rate = 1'b0;
	// Low 258, delay 3, high 5, low 4, three pulses
	logic [7:0]  cfg_val [12] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h03,
		8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h03};
	vstcfg_timing vstcfg_timing_inst (.clock(clock), .arst_n(arst_n), .pixel_en(pixel_en),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.vsync_high_count(vsync_high_count), .cfg_rdata(cfg_rdata),
		.vsync_out(vsync_out), .hsync_out(hsync_out));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Cycle stamp and hsync pulse tally
	always @(posedge clock) cyc <= cyc + 1;
	always @(posedge hsync_out) n_rise <= n_rise + 1;
	// Pixel enable: every cycle, or every other cycle in the half-rate scenario
	always @(posedge clock) pixel_en <= half_rate ? ~pixel_en : 1'b1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task test_done();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	// Write strobe stands for exactly one edge
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		cfg_write <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clock);
		cfg_write <= 1'b0;
	endtask : wr
	// Read data lags the address by one edge
	task rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock);
		cfg_addr <= a;
		repeat (2) @(posedge clock);
		#1 d = cfg_rdata;
	endtask : rd
	// Bounded wait for a sync level; a run-out ends the test
	task wait_on(input logic hs, input logic lvl, output int t);
		int k;
		for (k = 0; k < 3000; k++)
		begin
			@(posedge clock);
			#1;
			if ((hs ? hsync_out : vsync_out) === lvl)
				break;
		end
		t = cyc;
		if (k == 3000)
		begin
			n_mismatch++;
			test_done();
		end
	endtask : wait_on
	initial
	begin
		arst_n = 1'b0;
		cfg_write = 1'b0;
		cfg_addr = 12'h000;
		cfg_wdata = 8'h00;
		vsync_high_count = 24'h000014;
		// First edge applies reset even if the time-zero fall was missed
		@(posedge clock);
		#1 chk({vsync_out, hsync_out, cfg_rdata}, 10'h200);
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		// Reset value, then distinct pattern per byte
		for (i = 0; i < VSTCFG_NREG; i++)
		begin
			rd(VSTCFG_BASE + 12'(i), v);
			chk(v, 8'h00);
			wr(VSTCFG_BASE + 12'(i), 8'hA0 + 8'(i));
		end
		wr(12'h3E3, 8'hFF);
		wr(12'h3F0, 8'hFF);
		for (i = 0; i < VSTCFG_NREG; i++)
		begin
			rd(VSTCFG_BASE + 12'(i), v);
			chk(v, 8'hA0 + 8'(i));
		end
		rd(12'h3E3, v);
		chk(v, 8'h00);
		rd(12'h3F0, v);
		chk(v, 8'h00);
		// Second reset clears the long pattern counts
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		rd(VSTCFG_HS_LOW_HI, v);
		chk(v, 8'h00);
		for (i = 0; i < VSTCFG_NREG; i++)
			wr(VSTCFG_BASE + 12'(i), cfg_val[i]);
		// One full frame of the programmed waveform
		wait_on(1'b0, 1'b1, t0);
		wait_on(1'b0, 1'b0, t0);
		n0 = n_rise;
		wait_on(1'b1, 1'b1, t1);
		chk(t1 - t0, 3);
		for (i = 0; i < 3; i++)
		begin
			wait_on(1'b1, 1'b0, t2);
			chk(t2 - t1, 5);
			if (i < 2)
			begin
				wait_on(1'b1, 1'b1, t1);
				chk(t1 - t2, 4);
			end
		end
		wait_on(1'b0, 1'b1, tv);
		chk(tv - t0, 258);
		n0 = n_rise - n0;
		wait_on(1'b0, 1'b0, t0);
		chk(t0 - tv, 20);
		chk(n0, 3);
		// Zero pulse count gives a silent frame
		wait_on(1'b0, 1'b1, tv);
		wr(VSTCFG_PULSES_LO, 8'h00);
		n0 = n_rise;
		wait_on(1'b0, 1'b0, t0);
		wait_on(1'b0, 1'b1, tv);
		chk(n_rise - n0, 0);
		// Half-rate pixel enables stretch every period to twice the clocks
		half_rate = 1'b1;
		wait_on(1'b0, 1'b0, t0);
		wait_on(1'b0, 1'b1, tv);
		chk(tv - t0, 516);
		wait_on(1'b0, 1'b0, t0);
		chk(t0 - tv, 40);
		test_done();
	end
endmodule : testbench
bind vstcfg_timing vstcfg_asserts vstcfg_asserts_inst (.clock(clock), .arst_n(arst_n),
	.pixel_en(pixel_en), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
	.vsync_high_count(vsync_high_count), .cfg_rdata(cfg_rdata), .vsync_out(vsync_out),
	.hsync_out(hsync_out));
